/* File: src/i2c_pkg.sv */
// Shared constants and types for the two-wire sensor link ends
package i2c_pkg;

  // Clock rate of both ends
  localparam int CLK_MHZ      = 250;
  localparam int CLK_KHZ      = 250_000;
  // Power-up time before the target accepts traffic
  localparam int STARTUP_MS   = 15;
  localparam int STARTUP_CYC  = CLK_KHZ * STARTUP_MS;
  // Serial clock limits in the fast mode
  localparam int SCL_MAX_KHZ  = 400;
  localparam int SCL_LOW_NS   = 1300;
  localparam int SCL_HIGH_NS  = 600;
  // Quarter bit time; two quarters cover the longer low time
  localparam int LOW_CYC      = (SCL_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int QTR_CYC      = (LOW_CYC + 1) / 2;
  // Data valid time after the clock falls, read direction
  localparam int TVD_NS       = 400;
  localparam int TVD_CYC      = TVD_NS * CLK_MHZ / 1000;
  // Fixed target address and direction bit values
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic       DIR_RD   = 1'h1;
  localparam logic       DIR_WR   = 1'h0;

  // Target framing states
  typedef enum logic [2:0] {
    T_BOOT, T_SLEEP, T_ADDR, T_ACK, T_RX, T_TX, T_MACK, T_IGNORE
  } tgt_state_t;

  // Controller operations, one per user command
  typedef enum logic [1:0] {
    OP_START, OP_WRITE, OP_READ, OP_STOP
  } op_t;

  // Controller states
  typedef enum logic [1:0] {
    C_BOOT, C_READY, C_RUN
  } ctl_state_t;

endpackage : i2c_pkg

/* File: src/i2c_link.sv */
// Open-drain two-wire bus joining the controller and target ends
`timescale 1ns/10ps
interface i2c_link;
  // Controller pin drivers (enable low while pulling low)
  logic ctl_scl_o;
  logic ctl_scl_oen;
  logic ctl_sda_o;
  logic ctl_sda_oen;
  // Target pin drivers
  logic tgt_scl_o;
  logic tgt_scl_oen;
  logic tgt_sda_o;
  logic tgt_sda_oen;
  // Wired-AND with pull-ups: a released line reads high
  logic scl;
  logic sda;
  assign scl = (ctl_scl_oen | ctl_scl_o) & (tgt_scl_oen | tgt_scl_o);
  assign sda = (ctl_sda_oen | ctl_sda_o) & (tgt_sda_oen | tgt_sda_o);

  modport ctl (input scl, input sda,
               output ctl_scl_o, output ctl_scl_oen,
               output ctl_sda_o, output ctl_sda_oen);
  modport tgt (input scl, input sda,
               output tgt_scl_o, output tgt_scl_oen,
               output tgt_sda_o, output tgt_sda_oen);
endinterface : i2c_link

/* File: src/i2c_target.sv */
// Sensor-side two-wire target: framing, addressing, acknowledge, sleep
//
// Contract
// - Controller only pulls lines low, never high
// - Static logic; clock may pause indefinitely
// - Controller keeps serial clock within fast mode
// - Written bits sampled on rise, stable while high
// - Controller changes data only while clock low
// - Read bits driven after fall, held until next
// - Startup wait before idle; no earlier commands
// - Sleep automatically when not communicating
// - Transactions framed by Start and Stop
// - Start: data falls while clock high; busy
// - Stop: data rises while clock high; free
// - One fixed, non-configurable bus address
// - Answer address 1000000 plus direction bit
// - Acknowledge each good byte in ninth clock
`timescale 1ns/10ps
module i2c_target
  import i2c_pkg::*;
#(
  parameter int STARTUP = i2c_pkg::STARTUP_CYC // Power-up wait, cycles
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Bus side
  i2c_link.tgt            bus,
  // Data received from the controller
  output      logic [7:0] rx_data,
  output      logic       rx_valid,
  // Data returned to the controller
  input  wire logic [7:0] tx_data,
  output      logic       tx_taken,
  // Status
  output      logic       ready,
  output      logic       sleeping,
  output      logic       bus_busy,
  output      logic       selected,
  output      logic       read_dir
);
  import i2c_pkg::*;

  // Synchronisers and edge history
  logic       scl_m;        // First stage, read by second only
  logic       scl_s;        // Synchronised clock
  logic       scl_d;        // One cycle older
  logic       sda_m;
  logic       sda_s;
  logic       sda_d;
  // Framing state
  tgt_state_t state;
  logic [3:0] cnt;          // Rising edges seen in this byte
  logic [7:0] sh;           // Shift register
  logic       drv_low;      // Target pulls data low
  logic       nack;         // Controller refused the last byte
  logic [21:0] boot_cnt;    // Startup count

  // Edge and condition decode
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_cnd = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cnd  = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_end  = (cnt == 4'h8);
  wire addr_hit  = (sh[7:1] == DEV_ADDR);
  wire boot_done = (boot_cnt == 22'(STARTUP));

  // Only the data line is ever driven, and only low
  assign bus.tgt_sda_o   = 1'b0;
  assign bus.tgt_sda_oen = ~drv_low;
  // Clock stretching is not used by this end
  assign bus.tgt_scl_o   = 1'b0;
  assign bus.tgt_scl_oen = 1'b1;

  // Status outputs decoded from registered state
  assign ready    = (state != T_BOOT);
  assign sleeping = (state == T_SLEEP);
  assign bus_busy = ready && !sleeping;

  // Two-flop synchronisers; the pins come from another domain
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Startup counter; the bus is ignored until it expires
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      boot_cnt <= '0;
    else if (!boot_done)
      boot_cnt <= boot_cnt + 22'h1;
  end

  // Framing machine; after startup every step waits on a bus edge, so any clock
  // pause simply freezes it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state    <= T_BOOT;
      cnt      <= '0;
      sh       <= '0;
      drv_low  <= 1'b0;
      nack     <= 1'b0;
      rx_data  <= '0;
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      selected <= 1'b0;
      read_dir <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      if (state == T_BOOT)
      begin
        // Ready once the wait ends; stray traffic is not answered
        if (boot_done)
          state <= T_SLEEP;
      end
      else if (stop_cnd)
      begin
        // Bus free: release and fall asleep
        state    <= T_SLEEP;
        drv_low  <= 1'b0;
        selected <= 1'b0;
      end
      else if (start_cnd)
      begin
        // New sequence, also after a repeated Start
        state    <= T_ADDR;
        cnt      <= '0;
        drv_low  <= 1'b0;
        selected <= 1'b0;
      end
      else
      begin
        unique case (state)
          T_SLEEP, T_IGNORE:
          begin
            // Wait for a Start with the line released
            drv_low <= 1'b0;
          end
          T_ADDR, T_RX:
          begin
            if (scl_rise)
            begin
              sh  <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end
            else if (scl_fall && byte_end)
            begin
              if (state == T_RX)
              begin
                rx_data  <= sh;
                rx_valid <= 1'b1;
                drv_low  <= 1'b1;
                state    <= T_ACK;
              end
              else if (addr_hit)
              begin
                // Address 1000000 with direction in bit 0
                read_dir <= sh[0];
                selected <= 1'b1;
                drv_low  <= 1'b1;
                state    <= T_ACK;
              end
              else
                state <= T_IGNORE;
            end
          end
          T_ACK:
          begin
            // Ninth clock ends on its falling edge
            if (scl_fall)
            begin
              cnt <= '0;
              if (read_dir == DIR_RD)
              begin
                sh       <= {tx_data[6:0], 1'b0};
                drv_low  <= ~tx_data[7];
                tx_taken <= 1'b1;
                state    <= T_TX;
              end
              else
              begin
                drv_low <= 1'b0;
                state   <= T_RX;
              end
            end
          end
          T_TX:
          begin
            if (scl_rise)
              cnt <= cnt + 4'h1;
            else if (scl_fall)
            begin
              if (byte_end)
              begin
                // Hand the ninth clock to the controller
                drv_low <= 1'b0;
                state   <= T_MACK;
              end
              else
              begin
                // Next bit goes out a few cycles after the fall,
                // well inside the data valid time
                drv_low <= ~sh[7];
                sh      <= {sh[6:0], 1'b0};
              end
            end
          end
          T_MACK:
          begin
            if (scl_rise)
              nack <= sda_s;
            else if (scl_fall)
            begin
              cnt <= '0;
              if (nack)
                state <= T_IGNORE;
              else
              begin
                sh       <= {tx_data[6:0], 1'b0};
                drv_low  <= ~tx_data[7];
                tx_taken <= 1'b1;
                state    <= T_TX;
              end
            end
          end
          default:
            state <= T_SLEEP;
        endcase
      end
    end
  end

endmodule : i2c_target

/* File: src/i2c_ctl.sv */
// Microcontroller-side two-wire controller driving the sensor link
`timescale 1ns/10ps
module i2c_ctl
  import i2c_pkg::*;
#(
  parameter int STARTUP = i2c_pkg::STARTUP_CYC, // Power-up wait, cycles
  parameter int QTR     = i2c_pkg::QTR_CYC      // Quarter bit, cycles
)(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rstn,
  // Bus side
  i2c_link.ctl               bus,
  // Command request
  input  wire logic          cmd_valid,
  output      logic          cmd_ready,
  input  wire i2c_pkg::op_t  cmd_op,
  input  wire logic [7:0]    cmd_data,
  input  wire logic          cmd_ack,
  // Command result
  output      logic          done,
  output      logic [7:0]    rd_data,
  output      logic          got_ack,
  output      logic          boot_done
);
  import i2c_pkg::*;

  // Synchronisers
  logic        scl_m;
  logic        scl_s;
  logic        sda_m;
  logic        sda_s;
  // Sequencer
  ctl_state_t  state;
  op_t         op;
  logic [1:0]  ph;          // Quarter within the bit
  logic [3:0]  bitn;        // Bit within the byte, 8 is acknowledge
  logic [7:0]  sh;          // Outgoing and incoming byte
  logic        ack_out;     // Acknowledge to send after a read
  logic [15:0] qcnt;        // Quarter timer
  logic [21:0] boot_cnt;
  // Line levels wanted now; 1 means released
  logic        scl_rel;
  logic        sda_rel;

  // Levels per operation and quarter; byte data only moves in quarter 0,
  // where the clock is low; Start and Stop also move it in quarter 2, clock high
  function automatic logic [1:0] levels(input op_t o,
                                        input logic [1:0] p,
                                        input logic b);
    logic [1:0] r;
    r = 2'h0;
    unique case (o)
      OP_START: r = (p == 2'h0) ? 2'h3 : (p == 2'h1) ? 2'h3 :
                    (p == 2'h2) ? 2'h2 : 2'h0;
      OP_STOP:  r = (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h2 :
                    2'h3;
      default:  r = {(p == 2'h1) || (p == 2'h2), b};
    endcase
    return r;
  endfunction : levels

  // Data bit for the current slot: write byte then released ack,
  // or released read bits then our own acknowledge
  wire bit_now = (op == OP_WRITE) ? ((bitn == 4'h8) | sh[7]) :
                 ((bitn == 4'h8) ? ~ack_out : 1'b1);
  wire [1:0] lv  = levels(op, ph, bit_now);
  wire q_end     = (qcnt == 16'(QTR - 1));
  // A released clock that is still low is being held: wait
  wire stretched = lv[1] && !scl_s;
  wire step      = (state == C_RUN) && q_end && !stretched;
  wire byte_op   = (op == OP_WRITE) || (op == OP_READ);
  wire last_ph   = (ph == 2'h3) && (!byte_op || bitn == 4'h8);

  assign boot_done = (state != C_BOOT);
  assign cmd_ready = (state == C_READY);
  // Never drive high; a released line is pulled up outside
  assign bus.ctl_scl_o   = 1'b0;
  assign bus.ctl_sda_o   = 1'b0;
  assign bus.ctl_scl_oen = scl_rel;
  assign bus.ctl_sda_oen = sda_rel;

  // Two-flop synchronisers for the bus lines
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  // Quarter timer; four quarters per bit keep the rate under limit
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      qcnt <= '0;
    else if (state != C_RUN || step)
      qcnt <= '0;
    else if (!q_end)
      qcnt <= qcnt + 16'h1;
  end

  // Sequencer; the clock stays released through the startup wait
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state    <= C_BOOT;
      boot_cnt <= '0;
      op       <= OP_STOP;
      ph       <= '0;
      bitn     <= '0;
      sh       <= '0;
      ack_out  <= 1'b0;
      scl_rel  <= 1'b1;
      sda_rel  <= 1'b1;
      done     <= 1'b0;
      rd_data  <= '0;
      got_ack  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state)
        C_BOOT:
        begin
          boot_cnt <= boot_cnt + 22'h1;
          if (boot_cnt == 22'(STARTUP - 1))
            state <= C_READY;
        end
        C_READY:
        begin
          if (cmd_valid)
          begin
            op      <= cmd_op;
            sh      <= cmd_data;
            ack_out <= cmd_ack;
            ph      <= '0;
            bitn    <= '0;
            state   <= C_RUN;
          end
        end
        C_RUN:
        begin
          scl_rel <= lv[1];
          sda_rel <= lv[0];
          if (step)
          begin
            // Sample at the end of the second high quarter
            if (byte_op && ph == 2'h2)
            begin
              if (bitn == 4'h8)
                got_ack <= ~sda_s;
              else if (op == OP_READ)
                sh <= {sh[6:0], sda_s};
            end
            ph <= ph + 2'h1;
            if (ph == 2'h3 && byte_op && bitn != 4'h8)
            begin
              bitn <= bitn + 4'h1;
              if (op == OP_WRITE)
                sh <= {sh[6:0], 1'b0};
            end
            if (last_ph)
            begin
              if (op == OP_READ)
                rd_data <= sh;
              done  <= 1'b1;
              state <= C_READY;
            end
          end
        end
        default:
          state <= C_READY;
      endcase
    end
  end

endmodule : i2c_ctl

/* File: sim/i2c_link_monitor.sv */
// Checker watching the open-drain link between controller and target
`timescale 1ns/10ps
module i2c_link_monitor
  import i2c_pkg::*;
#(
  parameter int STARTUP = 50, // Power-up wait, cycles
  parameter int QTR     = 4   // Quarter bit, cycles
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Controller drivers
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oen,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oen,
  // Target drivers
  input wire logic tgt_scl_o,
  input wire logic tgt_scl_oen,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oen
);
  logic        scl_q;  // Line levels one cycle back
  logic        sda_q;
  logic [3:0]  cnt;    // Clock rises since Start, parks at 9
  logic [7:0]  hdr;    // First byte after a Start
  logic [7:0]  run;    // Samples of the clock at one level
  logic [31:0] bc;     // Cycles since reset, saturating
  wire         rise    = scl && !scl_q;
  wire         start_w = scl && scl_q && sda_q && !sda;
  wire         stop_w  = scl && scl_q && !sda_q && sda;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Line history, clock run length and boot count
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      run   <= 8'h00;
      bc    <= 32'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      // Saturate so a long pause cannot wrap into a short count
      run   <= (scl != scl_q) ? 8'h01 : (run == 8'hff ? run : run + 8'h01);
      bc    <= (bc < 32'(STARTUP)) ? bc + 32'h1 : bc;
    end
  end

  // Header capture; parking at 9 keeps later bytes out of it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 4'h9;
      hdr <= 8'h00;
    end
    else if (start_w)
      cnt <= 4'h0;
    else if (rise && cnt < 4'h9)
    begin
      cnt <= cnt + 4'h1;
      hdr <= (cnt < 4'h8) ? {hdr[6:0], sda} : hdr;
    end
  end

  sequence s_start;
    start_w;
  endsequence
  sequence s_hdr_ack;
    rise && cnt == 4'h8;
  endsequence

  property p_low_only;
    ctl_scl_o == 1'h0 && ctl_sda_o == 1'h0 && tgt_sda_o == 1'h0;
  endproperty
  property p_no_stretch;
    tgt_scl_oen && tgt_scl_o == 1'h0;
  endproperty
  property p_scl_run;
    scl != scl_q |-> run >= 8'(QTR);
  endproperty
  property p_ctl_hold;
    scl && scl_q && !start_w && !stop_w |-> $stable(ctl_sda_oen);
  endproperty
  property p_read_hold;
    scl && scl_q |-> $stable(tgt_sda_oen);
  endproperty
  property p_boot_quiet;
    bc < 32'(STARTUP) |-> ctl_scl_oen && ctl_sda_oen && tgt_sda_oen;
  endproperty
  property p_start_rel;
    s_start |-> tgt_sda_oen [*8];
  endproperty
  property p_addr_ack;
    s_hdr_ack ##0 hdr[7:1] == DEV_ADDR |-> !tgt_sda_oen;
  endproperty
  property p_foreign;
    s_hdr_ack ##0 hdr[7:1] != DEV_ADDR |-> tgt_sda_oen [*8];
  endproperty

  a_low_only: assert property (p_low_only)
    else $error("line driven high");
  a_no_stretch: assert property (p_no_stretch)
    else $error("target held the clock");
  a_scl_run: assert property (p_scl_run)
    else $error("clock phase too short");
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("controller data moved while clock high");
  a_read_hold: assert property (p_read_hold)
    else $error("target data moved while clock high");
  a_boot_quiet: assert property (p_boot_quiet)
    else $error("traffic during power-up wait");
  a_start_rel: assert property (p_start_rel)
    else $error("target drove data after Start");
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  a_foreign: assert property (p_foreign)
    else $error("foreign address acknowledged");
endmodule : i2c_link_monitor

/* File: sim/test_sensor_i2c_bus_framing.sv */
// Bench: controller and target joined, plus a faulty host on a second link
`timescale 1ns/10ps
module test_sensor_i2c_bus_framing;
  import i2c_pkg::*;
  localparam int SU = 50; // Shortened power-up wait
  localparam int QT = 4;  // Quarter bit of the controller
  logic       clock = 1'h0;
  logic       rstn = 1'h0;
  logic       cmd_valid = 1'h0;
  op_t        cmd_op = OP_STOP;
  logic [7:0] cmd_data = 8'h00;
  logic       cmd_ack = 1'h0;
  logic       s2 = 1'h1;       // Faulty host clock enable
  logic       d2 = 1'h1;       // Faulty host data enable
  logic       tk = 1'h0;       // Which returned byte is next
  logic [7:0] rdv [2];         // Bytes the target returns
  logic [7:0] rx_last, rx_cnt = 8'h00;
  logic [7:0] rd_data, rx_data;
  logic       cmd_ready, done, got_ack, boot_done, rx_valid, tx_taken;
  logic       ready, sleeping, bus_busy, selected, read_dir;
  logic       busy2, sleep2;
  integer     seed = 32'hae4c26b6;
  int         err_total = 0, cmp_count = 0, cyc = 0;
  wire  [7:0] tx_data = rdv[tk];

  i2c_link i2c_link_inst ();
  i2c_link i2c_link_inst2 ();
  assign i2c_link_inst2.ctl_scl_o = 1'h0;
  assign i2c_link_inst2.ctl_sda_o = 1'h0;
  assign i2c_link_inst2.ctl_scl_oen = s2;
  assign i2c_link_inst2.ctl_sda_oen = d2;

  i2c_ctl #(.STARTUP(SU), .QTR(QT)) i2c_ctl_inst (
    .clock(clock), .rstn(rstn), .bus(i2c_link_inst.ctl),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .done(done),
    .rd_data(rd_data), .got_ack(got_ack), .boot_done(boot_done));
  i2c_target #(.STARTUP(SU)) i2c_target_inst (
    .clock(clock), .rstn(rstn), .bus(i2c_link_inst.tgt),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_taken(tx_taken), .ready(ready), .sleeping(sleeping),
    .bus_busy(bus_busy), .selected(selected), .read_dir(read_dir));
  // Second target faces the rule-breaking host
  i2c_target #(.STARTUP(SU)) i2c_target_inst2 (
    .clock(clock), .rstn(rstn), .bus(i2c_link_inst2.tgt),
    .rx_data(), .rx_valid(), .tx_data(8'h00), .tx_taken(),
    .ready(), .sleeping(sleep2), .bus_busy(busy2), .selected(),
    .read_dir());
  i2c_link_monitor #(.STARTUP(SU), .QTR(QT)) i2c_link_monitor_inst (
    .clock(clock), .rstn(rstn),
    .scl(i2c_link_inst.scl), .sda(i2c_link_inst.sda),
    .ctl_scl_o(i2c_link_inst.ctl_scl_o),
    .ctl_scl_oen(i2c_link_inst.ctl_scl_oen),
    .ctl_sda_o(i2c_link_inst.ctl_sda_o),
    .ctl_sda_oen(i2c_link_inst.ctl_sda_oen),
    .tgt_scl_o(i2c_link_inst.tgt_scl_o),
    .tgt_scl_oen(i2c_link_inst.tgt_scl_oen),
    .tgt_sda_o(i2c_link_inst.tgt_sda_o),
    .tgt_sda_oen(i2c_link_inst.tgt_sda_oen));

  always #2 clock = ~clock;

  // Received bytes and returned-byte index; hang guard. Runs on the
  // falling edge so registered pulses are read half a cycle after launch
  always @(negedge clock)
  begin
    tk <= (tx_taken === 1'h1) ? ~tk : tk;
    if (rx_valid === 1'h1)
    begin
      rx_last <= rx_data;
      rx_cnt  <= rx_cnt + 8'h01;
    end
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("cmp_count %0d err_total %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One command; the settle wait covers the target's edge-detect lag
  task automatic cmd(input op_t op, input logic [7:0] d, input logic a);
    int n;
    for (n = 0; n < 2000 && cmd_ready !== 1'h1; n++) @(negedge clock);
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'h1;
    @(negedge clock);
    cmd_valid = 1'h0;
    for (n = 0; n < 2000 && done !== 1'h1; n++) @(negedge clock);
    chk({7'h00, done}, 8'h01);
    repeat (6) @(negedge clock);
  endtask : cmd

  // Expected acknowledge: only the fixed own address answers
  function automatic logic [7:0] acked(input logic [6:0] a);
    return {7'h00, a == DEV_ADDR};
  endfunction : acked

  // Write one byte to address a; only the own address may answer
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] hit, n0;
    hit = acked(a);
    n0 = rx_cnt;
    cmd(OP_START, 8'h00, 1'h0);
    chk({7'h00, bus_busy}, 8'h01);
    cmd(OP_WRITE, {a, DIR_WR}, 1'h0);
    chk({7'h00, got_ack}, hit);
    chk({7'h00, selected}, hit);
    // Clock parked low for a random while mid-transfer
    repeat ($random(seed) & 63) @(negedge clock);
    cmd(OP_WRITE, d, 1'h0);
    chk({7'h00, got_ack}, hit);
    chk(rx_cnt - n0, hit);
    if (hit == 8'h01) chk(rx_last, d);
    cmd(OP_STOP, 8'h00, 1'h0);
    chk({7'h00, bus_busy}, 8'h00);
    chk({7'h00, sleeping}, 8'h01);
  endtask : wr

  // Faulty host: hold clock and data enables for half a bit
  task automatic w2(input logic c, input logic d);
    s2 = c;
    d2 = d;
    repeat (16) @(negedge clock);
  endtask : w2

  task automatic bits2(input logic [7:0] v, input int n);
    for (int k = 7; k > 7 - n; k--)
    begin
      w2(1'h0, v[k]);
      w2(1'h1, v[k]);
    end
  endtask : bits2

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clock);
    rstn = 1'h1;
    cmd_valid = 1'h1; // Early request must be refused
    repeat (SU - 10) @(negedge clock);
    chk({5'h00, ready, cmd_ready, boot_done}, 8'h00);
    cmd_valid = 1'h0;
    repeat (20) @(negedge clock);
    chk({4'h0, ready, sleeping, boot_done, cmd_ready}, 8'h0f);
    for (int i = 0; i < 8; i++)
      wr((i % 2 == 0) ? DEV_ADDR : DEV_ADDR ^ ((i == 1) ? 7'h40 :
         (i == 3) ? 7'h01 : 7'($random(seed)) | 7'h01),
         (i == 0) ? 8'hff : 8'($random(seed)));
    // Repeated Start turns a write header into a read
    rdv[0] = 8'($random(seed));
    rdv[1] = 8'($random(seed));
    cmd(OP_START, 8'h00, 1'h0);
    cmd(OP_WRITE, {DEV_ADDR, DIR_WR}, 1'h0);
    cmd(OP_START, 8'h00, 1'h0);
    cmd(OP_WRITE, {DEV_ADDR, DIR_RD}, 1'h0);
    chk({6'h00, got_ack, read_dir}, 8'h03);
    cmd(OP_READ, 8'h00, 1'h1);
    chk(rd_data, rdv[0]);
    cmd(OP_READ, 8'h00, 1'h0);
    chk(rd_data, rdv[1]);
    cmd(OP_STOP, 8'h00, 1'h0);
    chk({6'h00, bus_busy, sleeping}, 8'h01);
    // Faulty host: Start, three bits, then data rises while clock high
    w2(1'h1, 1'h0);
    w2(1'h0, 1'h0);
    chk({7'h00, busy2}, 8'h01);
    bits2({DEV_ADDR, DIR_WR}, 3);
    w2(1'h1, 1'h1);
    chk({6'h00, busy2, sleep2}, 8'h01);
    // Whole header after the aborted one is still acknowledged
    w2(1'h1, 1'h0);
    w2(1'h0, 1'h0);
    bits2({DEV_ADDR, DIR_WR}, 8);
    w2(1'h0, 1'h1);
    w2(1'h1, 1'h1);
    chk({7'h00, i2c_link_inst2.sda}, 8'h00);
    w2(1'h0, 1'h0);
    w2(1'h1, 1'h0);
    w2(1'h1, 1'h1);
    chk({7'h00, busy2}, 8'h00);
    complete_run();
  end
endmodule : test_sensor_i2c_bus_framing
